// file: rtl/lsd_pkg.sv
//------------------------------------------------------------
// Purpose : Shared constants and types for the LCD segment link
// Assumes : One 80-column driver fed by one controller
// Notes   : Link timing counts derive from the system clock
//------------------------------------------------------------
package lsd_pkg;

  //----------------------------------------------------------
  // Column and data geometry
  //----------------------------------------------------------
  localparam int NUM_COLS = 80;
  localparam int NIB_W    = 4;
  localparam int CODE_W   = 2;
  // Shift pulses that fill one driver
  localparam int SHIFTS_PER_CHAIN = 20;
  localparam int CNT_W            = 5;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h14;

  //----------------------------------------------------------
  // Bias codes: {frame invert, latched bit}
  //----------------------------------------------------------
  localparam logic [CODE_W-1:0] BIAS_LEVEL_THREE = 2'h0;
  localparam logic [CODE_W-1:0] BIAS_LEVEL_ONE   = 2'h1;
  localparam logic [CODE_W-1:0] BIAS_LEVEL_FOUR  = 2'h2;
  localparam logic [CODE_W-1:0] BIAS_LEVEL_LOW   = 2'h3;

  //----------------------------------------------------------
  // Timing
  //----------------------------------------------------------
  localparam int CLK_NS   = 8;
  // Least width of any link clock or strobe phase
  localparam int PULSE_NS = 125;
  // Link clock half period rounds up to whole clk cycles
  localparam int LINK_HALF = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LINK_DIV  = 2 * LINK_HALF;
  localparam int DIV_W     = 6;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LINK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(LINK_HALF);
  localparam logic [DIV_W-1:0] DIV_TICK = DIV_W'(LINK_HALF - 1);

  //----------------------------------------------------------
  // Controller sequencer states
  //----------------------------------------------------------
  typedef enum logic [3:0] {
    ST_PRIME,
    ST_IDLE,
    ST_SHIFT_HI,
    ST_SHIFT_LO,
    ST_CHAIN_HI,
    ST_CHAIN_LO,
    ST_LATCH_HI,
    ST_LATCH_CK,
    ST_LATCH_END
  } lsd_ctl_e;

endpackage

// file: rtl/lsd_link_if.sv
//------------------------------------------------------------
// Purpose : Wires between the controller and the segment driver
// Assumes : Controller makes the link clock
// Notes   : Chain port levels are resolved here from the enables
//------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
interface lsd_link_if;
  logic       link_clk;
  logic       shift_clock;
  logic       chain_clock;
  logic       latch_strobe;
  logic       frame_invert;
  logic [3:0] pixel_nibble;
  logic       chain_feed;
  logic       chain_port_right_o;
  logic       chain_port_right_oe;
  logic       chain_port_right_i;
  logic       chain_port_left_o;
  logic       chain_port_left_oe;
  logic       chain_port_left_i;

  // A port not driven by the driver carries the controller feed
  assign chain_port_right_i = chain_port_right_oe ? chain_port_right_o : chain_feed;
  assign chain_port_left_i  = chain_port_left_oe ? chain_port_left_o : chain_feed;

  modport dev (
    input  link_clk, shift_clock, chain_clock, latch_strobe,
    input  frame_invert, pixel_nibble,
    input  chain_port_right_i, chain_port_left_i,
    output chain_port_right_o, chain_port_right_oe,
    output chain_port_left_o, chain_port_left_oe
  );

  modport ctl (
    output link_clk, shift_clock, chain_clock, latch_strobe,
    output frame_invert, pixel_nibble, chain_feed
  );
endinterface
`default_nettype wire

// file: rtl/lsd_seg_dev.sv
//------------------------------------------------------------
// Purpose : 80-column dot-matrix segment driver, link end
// Assumes : Link strobes change away from link_clk rising edges
// Notes   : All strobe edges are found by sampling on link_clk
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module lsd_seg_dev (
  // Link to the controller
  lsd_link_if.dev link,
  // Reset
  input  wire logic rst,
  // Strap from the board
  input  wire logic direction_select,
  // Column drive
  output logic [lsd_pkg::NUM_COLS-1:0][lsd_pkg::CODE_W-1:0] segment_outputs,
  output logic [lsd_pkg::NUM_COLS-1:0]                      pixel_on,
  // Power state
  output logic                                             standby
);
  import lsd_pkg::*;

  //----------------------------------------------------------
  // Declarations
  //----------------------------------------------------------
  logic                                 dir_meta;
  logic                                 dir_sync;
  logic                                 shift_prev;
  logic                                 chain_prev;
  logic                                 latch_prev;
  logic                                 shift_fall;
  logic                                 chain_fall;
  logic                                 latch_fall;
  logic                                 chain_in;
  logic                                 enable;
  logic                                 next_enable;
  logic [NUM_COLS-1:0]                  shift_reg;
  logic [NUM_COLS-1:0]                  next_shift_reg;
  logic [NUM_COLS-1:0]                  out_latch;
  logic [NUM_COLS-1:0]                  next_out_latch;
  logic [NUM_COLS-1:0][CODE_W-1:0]      next_segment_outputs;
  logic                                 next_standby;
  logic                                 next_right_o;
  logic                                 next_right_oe;
  logic                                 next_left_o;
  logic                                 next_left_oe;
  logic                                 right_o;
  logic                                 right_oe;
  logic                                 left_o;
  logic                                 left_oe;

  //----------------------------------------------------------
  // Strap synchroniser
  //----------------------------------------------------------
  // Two stages before the direction strap steers anything
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
    end else begin
      dir_meta <= direction_select;
      dir_sync <= dir_meta;
    end
  end

  //----------------------------------------------------------
  // Strobe edge detection
  //----------------------------------------------------------
  // Previous levels of the three link strobes
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      shift_prev <= 1'b0;
      chain_prev <= 1'b0;
      latch_prev <= 1'b0;
    end else begin
      shift_prev <= link.shift_clock;
      chain_prev <= link.chain_clock;
      latch_prev <= link.latch_strobe;
    end
  end

  // Falling edges seen as high then low
  always_comb begin
    shift_fall = shift_prev & ~link.shift_clock;
    chain_fall = chain_prev & ~link.chain_clock;
    latch_fall = latch_prev & ~link.latch_strobe;
  end

  //----------------------------------------------------------
  // Chain enable flip-flop
  //----------------------------------------------------------
  // Input side follows the direction strap
  always_comb begin
    chain_in = dir_sync ? link.chain_port_left_i : link.chain_port_right_i;
  end

  // Enable takes the upstream state at each chain clock fall,
  // so the active state walks one driver per pulse
  always_comb begin
    next_enable = enable;
    if (chain_fall) begin
      next_enable = chain_in;
    end
  end

  // Inactive from reset until the chain input sets it
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      enable <= 1'b0;
    end else begin
      enable <= next_enable;
    end
  end

  //----------------------------------------------------------
  // Four-wide shift register
  //----------------------------------------------------------
  // Shift by one nibble per shift clock fall, only when enabled
  always_comb begin
    next_shift_reg = shift_reg;
    if (shift_fall && enable) begin
      for (int i = 0; i < NUM_COLS; i++) begin
        if (!dir_sync) begin
          // Entry at the low columns, moving up by four
          if (i < NIB_W) begin
            next_shift_reg[i] = link.pixel_nibble[i];
          end else begin
            next_shift_reg[i] = shift_reg[i-NIB_W];
          end
        end else begin
          // Entry at the top column, moving down by four
          if (i >= NUM_COLS - NIB_W) begin
            next_shift_reg[i] = link.pixel_nibble[NUM_COLS-1-i];
          end else begin
            next_shift_reg[i] = shift_reg[i+NIB_W];
          end
        end
      end
    end
  end

  // Shift register storage
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= '0;
    end else begin
      shift_reg <= next_shift_reg;
    end
  end

  //----------------------------------------------------------
  // Output latch
  //----------------------------------------------------------
  // Whole register copied at the fall of the latch strobe
  always_comb begin
    next_out_latch = out_latch;
    if (latch_fall) begin
      next_out_latch = shift_reg;
    end
  end

  // Latch storage
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      out_latch <= '0;
    end else begin
      out_latch <= next_out_latch;
    end
  end

  //----------------------------------------------------------
  // Column drive and chain port outputs
  //----------------------------------------------------------
  // Bias code per column from inversion and latched bit only,
  // so loading the shift register never disturbs the drive
  always_comb begin
    for (int i = 0; i < NUM_COLS; i++) begin
      case ({link.frame_invert, next_out_latch[i]})
        2'h0:    next_segment_outputs[i] = BIAS_LEVEL_THREE;
        2'h1:    next_segment_outputs[i] = BIAS_LEVEL_ONE;
        2'h2:    next_segment_outputs[i] = BIAS_LEVEL_FOUR;
        default: next_segment_outputs[i] = BIAS_LEVEL_LOW;
      endcase
    end
  end

  // Standby whenever this driver holds no enable
  always_comb begin
    next_standby = ~next_enable;
  end

  // Output side drives the enable state to the next driver
  always_comb begin
    next_right_oe = dir_sync;
    next_left_oe  = ~dir_sync;
    next_right_o  = dir_sync & next_enable;
    next_left_o   = ~dir_sync & next_enable;
  end

  // Registered outputs
  always_ff @(posedge link.link_clk or posedge rst) begin
    if (rst) begin
      segment_outputs <= {NUM_COLS{BIAS_LEVEL_THREE}};
      pixel_on        <= '0;
      standby         <= 1'b1;
      right_o         <= 1'b0;
      right_oe        <= 1'b0;
      left_o          <= 1'b0;
      left_oe         <= 1'b1;
    end else begin
      segment_outputs <= next_segment_outputs;
      pixel_on        <= next_out_latch;
      standby         <= next_standby;
      right_o         <= next_right_o;
      right_oe        <= next_right_oe;
      left_o          <= next_left_o;
      left_oe         <= next_left_oe;
    end
  end

  // Chain port pins
  assign link.chain_port_right_o  = right_o;
  assign link.chain_port_right_oe = right_oe;
  assign link.chain_port_left_o   = left_o;
  assign link.chain_port_left_oe  = left_oe;

endmodule
`default_nettype wire

// file: rtl/lsd_ctrl.sv
//------------------------------------------------------------
// Purpose : Controller end feeding one segment driver chain
// Assumes : User holds a nibble until it is accepted
// Notes   : Link strobes change as link_clk falls
//------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module lsd_ctrl (
  // System clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // Link to the driver
  lsd_link_if.ctl                        link,
  // Nibble stream from the user
  input  wire logic                      nib_valid,
  input  wire logic [lsd_pkg::NIB_W-1:0] nib_data,
  input  wire logic                      nib_line_end,
  input  wire logic                      nib_frame_end,
  output logic                           nib_accept
);
  import lsd_pkg::*;

  //----------------------------------------------------------
  // Declarations
  //----------------------------------------------------------
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             tick;
  logic             link_clk;
  logic             next_link_clk;
  lsd_ctl_e         state;
  lsd_ctl_e         next_state;
  logic [CNT_W-1:0] shift_cnt;
  logic [CNT_W-1:0] next_shift_cnt;
  logic             line_pend;
  logic             next_line_pend;
  logic             frame_pend;
  logic             next_frame_pend;
  logic             shift_clock;
  logic             next_shift_clock;
  logic             chain_clock;
  logic             next_chain_clock;
  logic             latch_strobe;
  logic             next_latch_strobe;
  logic             frame_invert;
  logic             next_frame_invert;
  logic [NIB_W-1:0] pixel_nibble;
  logic [NIB_W-1:0] next_pixel_nibble;
  logic             chain_feed;
  logic             next_nib_accept;

  //----------------------------------------------------------
  // Link clock divider
  //----------------------------------------------------------
  // High for the first half count; tick sits just before the fall
  always_comb begin
    next_div_cnt  = (div_cnt == DIV_LAST) ? '0 : div_cnt + 1'b1;
    next_link_clk = (next_div_cnt < DIV_HALF);
    tick          = (div_cnt == DIV_TICK);
  end

  // Divider storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt  <= '0;
      link_clk <= 1'b0;
    end else begin
      div_cnt  <= next_div_cnt;
      link_clk <= next_link_clk;
    end
  end

  //----------------------------------------------------------
  // Link sequencer
  //----------------------------------------------------------
  // One link phase per tick; strobes held a full link period
  always_comb begin
    next_state        = state;
    next_shift_cnt    = shift_cnt;
    next_line_pend    = line_pend;
    next_frame_pend   = frame_pend;
    next_shift_clock  = shift_clock;
    next_chain_clock  = chain_clock;
    next_latch_strobe = latch_strobe;
    next_frame_invert = frame_invert;
    next_pixel_nibble = pixel_nibble;
    next_nib_accept   = 1'b0;
    if (tick) begin
      case (state)
        ST_PRIME: begin
          // Opening strobe enables the first driver
          next_latch_strobe = 1'b1;
          next_state        = ST_LATCH_HI;
        end
        ST_IDLE: begin
          if (nib_valid) begin
            next_pixel_nibble = nib_data;
            next_line_pend    = nib_line_end;
            next_frame_pend   = nib_frame_end;
            next_shift_clock  = 1'b1;
            next_nib_accept   = 1'b1;
            next_state        = ST_SHIFT_HI;
          end
        end
        ST_SHIFT_HI: begin
          next_shift_clock = 1'b0;
          next_shift_cnt   = shift_cnt + 1'b1;
          next_state       = ST_SHIFT_LO;
        end
        ST_SHIFT_LO: begin
          if (shift_cnt == CNT_FULL) begin
            // Hand the enable on after every driver's worth
            next_chain_clock = 1'b1;
            next_shift_cnt   = '0;
            next_state       = ST_CHAIN_HI;
          end else if (line_pend) begin
            next_latch_strobe = 1'b1;
            next_state        = ST_LATCH_HI;
          end else begin
            next_state = ST_IDLE;
          end
        end
        ST_CHAIN_HI: begin
          next_chain_clock = 1'b0;
          next_state       = ST_CHAIN_LO;
        end
        ST_CHAIN_LO: begin
          if (line_pend) begin
            next_latch_strobe = 1'b1;
            next_state        = ST_LATCH_HI;
          end else begin
            next_state = ST_IDLE;
          end
        end
        ST_LATCH_HI: begin
          // Chain pulse inside the strobe restarts the cascade
          next_chain_clock = 1'b1;
          next_state       = ST_LATCH_CK;
        end
        ST_LATCH_CK: begin
          next_chain_clock = 1'b0;
          next_state       = ST_LATCH_END;
        end
        ST_LATCH_END: begin
          next_latch_strobe = 1'b0;
          next_shift_cnt    = '0;
          next_line_pend    = 1'b0;
          next_frame_pend   = 1'b0;
          if (frame_pend) begin
            next_frame_invert = ~frame_invert;
          end
          next_state = ST_IDLE;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state        <= ST_PRIME;
      shift_cnt    <= '0;
      line_pend    <= 1'b0;
      frame_pend   <= 1'b0;
      shift_clock  <= 1'b0;
      chain_clock  <= 1'b0;
      latch_strobe <= 1'b0;
      frame_invert <= 1'b0;
      pixel_nibble <= '0;
      chain_feed   <= 1'b0;
      nib_accept   <= 1'b0;
    end else begin
      state        <= next_state;
      shift_cnt    <= next_shift_cnt;
      line_pend    <= next_line_pend;
      frame_pend   <= next_frame_pend;
      shift_clock  <= next_shift_clock;
      chain_clock  <= next_chain_clock;
      latch_strobe <= next_latch_strobe;
      frame_invert <= next_frame_invert;
      pixel_nibble <= next_pixel_nibble;
      chain_feed   <= next_latch_strobe;
      nib_accept   <= next_nib_accept;
    end
  end

  // Link pins
  assign link.link_clk     = link_clk;
  assign link.shift_clock  = shift_clock;
  assign link.chain_clock  = chain_clock;
  assign link.latch_strobe = latch_strobe;
  assign link.frame_invert = frame_invert;
  assign link.pixel_nibble = pixel_nibble;
  assign link.chain_feed   = chain_feed;

endmodule
`default_nettype wire

// file: verif/lsd_link_props.sv
// Purpose : Protocol checks on the link between controller and driver
// Assumes : One driver; strobes are sampled on link_clk rising edges
// Notes   : Instantiated beside the link interface, no bind
`timescale 1ns/1ns
`default_nettype none
module lsd_link_props (
  // Link clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // Controller strobes
  input wire logic shift_clock,
  input wire logic chain_clock,
  input wire logic latch_strobe,
  input wire logic frame_invert,
  input wire logic chain_feed,
  // Driver chain ports
  input wire logic chain_port_left_o,
  input wire logic chain_port_left_oe,
  input wire logic chain_port_right_o,
  input wire logic chain_port_right_oe,
  // Driver strap and power state
  input wire logic direction_select,
  input wire logic standby
);
  import lsd_pkg::*;

  logic [CNT_W-1:0] shift_cnt;
  logic [CNT_W-1:0] next_shift_cnt;
  logic             shift_q;
  logic             chain_q;
  logic [1:0]       arm;

  // Shift falls since the last chain clock fall
  always_comb begin
    next_shift_cnt = shift_cnt;
    if (chain_q && !chain_clock) begin
      next_shift_cnt = '0;
    end else if (shift_q && !shift_clock) begin
      next_shift_cnt = shift_cnt + 5'h01;
    end
  end

  // Register the counter and the previous strobe levels
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      shift_cnt <= '0;
      shift_q   <= 1'b0;
      chain_q   <= 1'b0;
      arm       <= '0;
    end else begin
      shift_cnt <= next_shift_cnt;
      shift_q   <= shift_clock;
      chain_q   <= chain_clock;
      arm       <= {arm[0], 1'b1};
    end
  end

  //----------------------------------------------------------
  // Link rules
  //----------------------------------------------------------
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (rst || !arm[1]); // Held off until the link has some history

  property p_feed; chain_feed == latch_strobe; endproperty
  a_feed: assert property (p_feed) else $error("chain feed differs from latch");
  property p_latch; $rose(latch_strobe) |-> latch_strobe [*3] ##1 !latch_strobe; endproperty
  a_latch: assert property (p_latch) else $error("latch strobe width wrong");
  property p_twenty; $rose(chain_clock) && !latch_strobe |-> shift_cnt == CNT_FULL; endproperty
  a_twenty: assert property (p_twenty) else $error("chain clock not after 20 shifts");
  property p_en_set;
    $fell(standby) |-> ($past(chain_clock, 2) && $past(latch_strobe, 2))
                    || ($past(chain_clock, 3) && $past(latch_strobe, 3));
  endproperty
  a_en_set: assert property (p_en_set) else $error("enable set without chain fall");
  property p_en_pass; $rose(standby) |-> $past(chain_clock, 2) || $past(chain_clock, 3); endproperty
  a_en_pass: assert property (p_en_pass) else $error("enable left without chain fall");
  property p_chain_out;
    (!chain_port_left_oe || chain_port_left_o == !standby)
    && (!chain_port_right_oe || chain_port_right_o == !standby);
  endproperty
  a_chain_out: assert property (p_chain_out) else $error("chain output not enable");
  property p_dir;
    $stable(direction_select) [*8] |-> chain_port_right_oe == direction_select
                                     && chain_port_left_oe == !direction_select;
  endproperty
  a_dir: assert property (p_dir) else $error("chain port direction wrong");
  property p_frame; $changed(frame_invert) |-> $fell(latch_strobe); endproperty
  a_frame: assert property (p_frame) else $error("frame inversion off latch end");
endmodule
`default_nettype wire

// file: verif/lcd_segment_column_driver_tb_top.sv
// Purpose : Self-checking bench for controller and segment driver
// Assumes : Lines of 20 nibbles; a second driver is stirred by the bench
// Notes   : The second driver shows shifts refused while not enabled
`timescale 1ns/1ns
`default_nettype none
module lcd_segment_column_driver_tb_top;
  import lsd_pkg::*;
  //----------------------------------------------------------
  // Signals and instances
  //----------------------------------------------------------
  logic                            clk;
  logic                            rst;
  logic                            nib_valid;
  logic [3:0]                      nib_data;
  logic                            nib_line_end, nib_frame_end;
  logic                            nib_accept;
  logic                            direction_select;
  logic [NUM_COLS-1:0][CODE_W-1:0] seg, seg_b;
  logic [NUM_COLS-1:0]             pix, pix_b;
  logic                            standby, standby_b;
  logic [NUM_COLS-1:0]             exp_pix;
  logic                            exp_fi;
  int                              error_cnt;
  int                              tests_run;
  lsd_link_if link ();
  lsd_link_if link_b ();

  lsd_ctrl i_lsd_ctrl (.clk(clk), .rst(rst), .link(link), .nib_valid(nib_valid),
    .nib_data(nib_data), .nib_line_end(nib_line_end), .nib_frame_end(nib_frame_end),
    .nib_accept(nib_accept));
  lsd_seg_dev i_lsd_seg_dev (.link(link), .rst(rst), .direction_select(direction_select),
    .segment_outputs(seg), .pixel_on(pix), .standby(standby));
  lsd_seg_dev i_lsd_seg_dev_b (.link(link_b), .rst(rst), .direction_select(1'b0),
    .segment_outputs(seg_b), .pixel_on(pix_b), .standby(standby_b));
  lsd_link_props i_lsd_link_props (.link_clk(link.link_clk), .rst(rst),
    .shift_clock(link.shift_clock), .chain_clock(link.chain_clock),
    .latch_strobe(link.latch_strobe), .frame_invert(link.frame_invert),
    .chain_feed(link.chain_feed), .chain_port_left_o(link.chain_port_left_o),
    .chain_port_left_oe(link.chain_port_left_oe), .chain_port_right_o(link.chain_port_right_o),
    .chain_port_right_oe(link.chain_port_right_oe), .direction_select(direction_select),
    .standby(standby));

  // System clock and the bench-made link clock of the second driver
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    link_b.link_clk = 1'b0;
    forever begin
      #63 link_b.link_clk = 1'b1;
      #62 link_b.link_clk = 1'b0;
    end
  end

  //----------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------
  task automatic chk(input logic [159:0] got, input logic [159:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic hang();
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    stop_test();
  endtask

  // Model of the shift register: new nibble enters at the input side
  function automatic logic [79:0] place(input logic [79:0] cur, input logic [3:0] d,
                                        input logic hi);
    if (!hi) return {cur[75:0], d};
    return {d[0], d[1], d[2], d[3], cur[79:4]};
  endfunction

  // Bias code per column from latched bit and frame inversion
  function automatic logic [159:0] seg_exp();
    logic [159:0] e;
    for (int c = 0; c < NUM_COLS; c++) begin
      e[2*c +: 2] = exp_pix[c] ? (exp_fi ? BIAS_LEVEL_LOW : BIAS_LEVEL_ONE)
                               : (exp_fi ? BIAS_LEVEL_FOUR : BIAS_LEVEL_THREE);
    end
    return e;
  endfunction

  // Wait for the latch strobe to rise and fall, then let outputs settle
  task automatic wait_latch();
    int n;
    n = 0;
    while (link.latch_strobe !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    while (link.latch_strobe !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) hang();
    repeat (48) @(posedge clk);
    #1;
  endtask

  // One full line of 20 nibbles, then latch and check every column
  task automatic send_line(input logic [3:0] seed, input logic fe);
    logic [79:0] sr;
    int          n;
    sr = '0;
    @(posedge clk);
    #1;
    for (int j = 0; j < SHIFTS_PER_CHAIN; j++) begin
      if (j == 10) begin
        chk(pix, exp_pix, "columns moved before latch");
        chk(standby, 1'b0, "driver idle while loading");
      end
      nib_valid     = 1'b1;
      nib_data      = seed + 4'(j * 5);
      nib_line_end  = (j == SHIFTS_PER_CHAIN - 1);
      nib_frame_end = fe;
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (nib_accept !== 1'b1 && n < 500);
      if (n >= 500) hang();
      sr = place(sr, nib_data, direction_select);
    end
    nib_valid = 1'b0;
    wait_latch();
    exp_pix = sr;
    if (fe) exp_fi = ~exp_fi;
    chk(pix, exp_pix, "latched columns wrong");
    chk(seg, seg_exp(), "bias codes wrong");
  endtask

  // Second driver: one link step of shift, chain and latch levels
  task automatic drv_b(input logic s, input logic c, input logic l);
    @(negedge link_b.link_clk);
    link_b.shift_clock  = s;
    link_b.chain_clock  = c;
    link_b.latch_strobe = l;
    link_b.chain_feed   = l;
  endtask

  task automatic pulse_b(input int shifts, input logic en);
    repeat (shifts) begin
      drv_b(1'b1, 1'b0, 1'b0);
      drv_b(1'b0, 1'b0, 1'b0);
    end
    drv_b(1'b0, 1'b0, 1'b1);
    drv_b(1'b0, en, 1'b1);
    drv_b(1'b0, 1'b0, 1'b1);
    repeat (3) drv_b(1'b0, 1'b0, 1'b0);
  endtask

  // Shifts to a driver never enabled are dropped; once enabled they land
  task automatic t_refused();
    pulse_b(20, 1'b0);
    chk(pix_b, '0, "shift taken while idle");
    chk(standby_b, 1'b1, "idle driver woke");
    pulse_b(0, 1'b1);
    chk(standby_b, 1'b0, "strobe did not enable");
    pulse_b(20, 1'b1);
    chk(pix_b, {NUM_COLS{1'b1}}, "enabled driver missed data");
  endtask

  //----------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------
  initial begin
    rst = 1'b0;
    {nib_valid, nib_data, nib_line_end, nib_frame_end, direction_select} = '0;
    {link_b.shift_clock, link_b.chain_clock, link_b.latch_strobe} = '0;
    {link_b.chain_feed, link_b.frame_invert} = '0;
    link_b.pixel_nibble = 4'hf;
    exp_pix = '0;
    exp_fi = 1'b0;
    error_cnt = 0;
    tests_run = 0;
    #1 rst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(standby, 1'b1, "enabled in reset");
    chk(seg, '0, "bias codes not cleared");
    rst = 1'b0;
    t_refused();
    send_line(4'h3, 1'b1);
    send_line(4'ha, 1'b0);
    direction_select = 1'b1;
    repeat (128) @(posedge clk);
    #1;
    chk(link.chain_port_right_oe, 1'b1, "right port not output");
    chk(link.chain_port_right_o, 1'b1, "right port not enable");
    send_line(4'h6, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
